//--- core/ucmd_host.v
`include "ucmd_consts.vh"
module ucmd_host #(
   parameter [31:0] BIT_CYCLES =
      (`UCMD_CLK_HZ + `UCMD_BAUD / 2) / `UCMD_BAUD,
   parameter [31:0] GAP_CYCLES =
      (`UCMD_CLK_HZ / `UCMD_MS_DIV) * `UCMD_GAP_MS,
   parameter [31:0] SLOT_CYCLES =
      (`UCMD_CLK_HZ / `UCMD_MS_DIV) * `UCMD_SLOT_MS,
   parameter [31:0] RSP_TO_CYCLES =
      (`UCMD_CLK_HZ / `UCMD_MS_DIV) * `UCMD_RSP_TO_MS,
   parameter [31:0] RETRY_CYCLES =
      (`UCMD_CLK_HZ / `UCMD_MS_DIV) * `UCMD_RETRY_MS,
   parameter [1:0] MAX_TRIES = `UCMD_MAX_TRIES
) (
   input wire CORE_CLK,
   input wire NRST,
   input wire CMD_START,
   input wire [3:0] CMD_CODE,
   input wire [19:0] CMD_FREQ,
   output wire CMD_BUSY,
   output wire CMD_DONE,
   output wire CMD_FAIL,
   output wire [23:0] READ_FREQ,
   output wire TXD,
   input wire RXD
);
   // ==========================================
   // sequencer states
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_SEND = 6'h02;
   localparam [5:0] S_WRSP = 6'h04;
   localparam [5:0] S_WAIT = 6'h08;
   localparam [5:0] S_READ = 6'h10;
   localparam [5:0] S_BACK = 6'h20;

   // byte idx of the session: call pair, frame one, frame two
   function [7:0] ucmd_byte;
      input [2:0] idx;
      input [3:0] cmd;
      input [19:0] f;
      begin
         case (idx)
            3'h0: ucmd_byte = `UCMD_CALL0;
            3'h1: ucmd_byte = `UCMD_CALL1;
            3'h2: ucmd_byte = {4'h0, f[3:0]};
            3'h3: ucmd_byte = f[11:4];
            3'h4: ucmd_byte = f[19:12];
            default: ucmd_byte = {4'h0, cmd};
         endcase
      end
   endfunction

   // ==========================================
   // receive path, two-flop synchroniser first
   reg rxd_s1_q, rxd_s2_q;
   reg rx_busy_q, rx_valid_q;
   reg [31:0] rx_cnt_q;
   reg [3:0] rx_bit_q;
   reg [7:0] rx_sh_q, rx_data_q;

   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rxd_s1_q <= 1'b1;
         rxd_s2_q <= 1'b1;
      end else begin
         rxd_s1_q <= RXD;
         rxd_s2_q <= rxd_s1_q;
      end
   end

   // mid-bit sampling; a glitch start is dropped at the centre check
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rx_busy_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_cnt_q <= 32'h0;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_data_q <= 8'h00;
      end else begin
         rx_valid_q <= 1'b0;
         if (!rx_busy_q) begin
            if (!rxd_s2_q) begin
               rx_busy_q <= 1'b1;
               rx_cnt_q <= BIT_CYCLES >> 1;
               rx_bit_q <= 4'h0;
            end
         end else if (rx_cnt_q != 32'h0) begin
            rx_cnt_q <= rx_cnt_q - 32'h1;
         end else begin
            rx_cnt_q <= BIT_CYCLES - 32'h1;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0) begin
               if (rxd_s2_q)
                  rx_busy_q <= 1'b0;
            end else if (rx_bit_q == `UCMD_STOP_BIT) begin
               rx_busy_q <= 1'b0;
               rx_valid_q <= rxd_s2_q;
               rx_data_q <= rx_sh_q;
            end else begin
               rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
            end
         end
      end
   end

   // ==========================================
   // transmit path
   reg [5:0] state_q;
   reg tx_busy_q, tx_line_q;
   reg [31:0] tx_cnt_q;
   reg [3:0] tx_bit_q;
   reg [9:0] tx_sh_q;
   reg [2:0] idx_q, end_q;
   reg [3:0] cmd_q;
   reg [19:0] freq_q;
   wire tx_start = state_q[1] && !tx_busy_q;

   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         tx_busy_q <= 1'b0;
         tx_line_q <= 1'b1;
         tx_cnt_q <= 32'h0;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 10'h3FF;
      end else if (tx_start) begin
         tx_busy_q <= 1'b1;
         tx_line_q <= 1'b0;
         tx_cnt_q <= BIT_CYCLES - 32'h1;
         tx_bit_q <= 4'h1;
         tx_sh_q <= {1'b1, ucmd_byte(idx_q, cmd_q, freq_q), 1'b0};
      end else if (tx_busy_q) begin
         if (tx_cnt_q != 32'h0) begin
            tx_cnt_q <= tx_cnt_q - 32'h1;
         end else if (tx_bit_q == `UCMD_TX_BITS) begin
            tx_busy_q <= 1'b0;
            tx_line_q <= 1'b1;
         end else begin
            tx_cnt_q <= BIT_CYCLES - 32'h1;
            tx_line_q <= tx_sh_q[tx_bit_q];
            tx_bit_q <= tx_bit_q + 4'h1;
         end
      end
   end

   // ==========================================
   // session sequencer
   reg [1:0] step_q, tries_q, nrd_q;
   reg [7:0] exp_q;
   reg [31:0] tmr_q;
   reg [23:0] rd_q;
   reg done_q, fail_q;
   wire rsp_ok = rx_valid_q && (rx_data_q == exp_q);
   wire wait_end = (step_q == 2'h0) ? (tmr_q >= GAP_CYCLES) :
                   (tmr_q >= SLOT_CYCLES);

   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= S_IDLE;
         step_q <= 2'h0;
         tries_q <= 2'h0;
         nrd_q <= 2'h0;
         idx_q <= 3'h0;
         end_q <= 3'h0;
         exp_q <= 8'h00;
         cmd_q <= 4'h0;
         freq_q <= 20'h00000;
         tmr_q <= 32'h0;
         rd_q <= 24'h000000;
         done_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
         tmr_q <= tmr_q + 32'h1;
         case (state_q)
            S_IDLE: begin
               if (CMD_START) begin
                  cmd_q <= CMD_CODE;
                  freq_q <= CMD_FREQ;
                  tries_q <= 2'h0;
                  step_q <= 2'h0;
                  idx_q <= `UCMD_IDX_CALL;
                  end_q <= `UCMD_IDX_CALL + 3'h1;
                  exp_q <= `UCMD_READY;
                  state_q <= S_SEND;
               end
            end
            S_SEND: begin
               if (tx_start) begin
                  idx_q <= idx_q + 3'h1;
                  tmr_q <= 32'h0;
                  if (idx_q == end_q)
                     state_q <= S_WRSP;
               end
            end
            S_WRSP: begin
               // other bytes are ignored; only the expected one counts
               if (rsp_ok) begin
                  tmr_q <= 32'h0;
                  if (step_q != 2'h2) begin
                     state_q <= S_WAIT;
                  end else if (cmd_q == `UCMD_CMD_READ) begin
                     nrd_q <= 2'h0;
                     state_q <= S_READ;
                  end else begin
                     done_q <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end else if (tmr_q >= RSP_TO_CYCLES) begin
                  tmr_q <= 32'h0;
                  state_q <= S_BACK;
               end
            end
            S_WAIT: begin
               // fixed gap keeps frame one well inside the lost window
               if (wait_end) begin
                  idx_q <= (step_q == 2'h0) ? `UCMD_IDX_F1 : `UCMD_IDX_F2;
                  end_q <= (step_q == 2'h0) ? `UCMD_IDX_F1 + 3'h1 :
                           `UCMD_IDX_F2 + 3'h1;
                  exp_q <= `UCMD_ACK;
                  step_q <= step_q + 2'h1;
                  state_q <= S_SEND;
               end
            end
            S_READ: begin
               if (rx_valid_q) begin
                  rd_q <= {rx_data_q, rd_q[23:8]};
                  nrd_q <= nrd_q + 2'h1;
                  tmr_q <= 32'h0;
                  if (nrd_q == `UCMD_RD_BYTES - 2'h1) begin
                     done_q <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end else if (tmr_q >= RSP_TO_CYCLES) begin
                  tmr_q <= 32'h0;
                  state_q <= S_BACK;
               end
            end
            S_BACK: begin
               // device drops back to idle, so restart from the call
               if (tries_q == MAX_TRIES - 2'h1) begin
                  fail_q <= 1'b1;
                  state_q <= S_IDLE;
               end else if (tmr_q >= RETRY_CYCLES) begin
                  tries_q <= tries_q + 2'h1;
                  step_q <= 2'h0;
                  idx_q <= `UCMD_IDX_CALL;
                  end_q <= `UCMD_IDX_CALL + 3'h1;
                  exp_q <= `UCMD_READY;
                  state_q <= S_SEND;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   assign CMD_BUSY = !state_q[0];
   assign CMD_DONE = done_q;
   assign CMD_FAIL = fail_q;
   assign READ_FREQ = rd_q;
   assign TXD = tx_line_q;
endmodule

//--- inc/ucmd_consts.vh
`ifndef UCMD_CONSTS_VH
`define UCMD_CONSTS_VH
// ==========================================
// timing
`define UCMD_CLK_HZ 100000000
`define UCMD_BAUD 9600
`define UCMD_MS_DIV 1000
`define UCMD_GAP_MS 40
`define UCMD_SLOT_MS 5
`define UCMD_RSP_TO_MS 100
`define UCMD_RETRY_MS 2000
`define UCMD_MAX_TRIES 3
// ==========================================
// link bytes and framing
`define UCMD_CALL0 8'h99
`define UCMD_CALL1 8'hAA
`define UCMD_READY 8'hBB
`define UCMD_ACK 8'hCC
`define UCMD_CMD_READ 4'h4
`define UCMD_STOP_BIT 4'h9
`define UCMD_TX_BITS 4'hA
`define UCMD_RD_BYTES 2'h3
`define UCMD_IDX_CALL 3'h0
`define UCMD_IDX_F1 3'h2
`define UCMD_IDX_F2 3'h4
`endif

//--- verif/ucmd_host_chk.sv
module ucmd_host_chk #(
   parameter [31:0] BIT_CYCLES = 32'h10
) (
   input wire CORE_CLK,
   input wire NRST,
   input wire CMD_START,
   input wire CMD_BUSY,
   input wire CMD_DONE,
   input wire CMD_FAIL,
   input wire [23:0] READ_FREQ,
   input wire TXD
);
   // ==========================================
   // session framing, delays assume 16-cycle bits
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   chk_start_taken: assert property
      (CMD_START && !CMD_BUSY |=> CMD_BUSY) else $error("start lost");
   chk_start_bit: assert property
      ($rose(CMD_BUSY) |=> !TXD [*8]) else $error("no start bit");
   chk_call_lsb: assert property
      ($rose(CMD_BUSY) |-> ##24 TXD ##16 !TXD ##16 !TXD ##16 TXD)
      else $error("call byte order");
   chk_call_join: assert property
      ($rose(CMD_BUSY) |-> ##152 TXD ##16 !TXD)
      else $error("stop or second call byte");
   chk_idle_line: assert property
      (!CMD_BUSY |-> TXD) else $error("line not idle");
   chk_done_pulse: assert property
      (CMD_DONE |=> !CMD_DONE) else $error("done too long");
   chk_fail_pulse: assert property
      (CMD_FAIL |=> !CMD_FAIL) else $error("fail too long");
   // busy falls on the same edge that raises the end pulse
   chk_busy_end: assert property
      ((CMD_DONE || CMD_FAIL) |-> !CMD_BUSY && $past(CMD_BUSY))
      else $error("busy not dropped");
   chk_read_hold: assert property
      (!CMD_BUSY |=> $stable(READ_FREQ)) else $error("read moved");
   cover property (CMD_DONE);
   cover property (CMD_FAIL);
   cover property (CMD_START && CMD_BUSY);
endmodule
bind ucmd_host ucmd_host_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
   .CORE_CLK(CORE_CLK), .NRST(NRST), .CMD_START(CMD_START),
   .CMD_BUSY(CMD_BUSY), .CMD_DONE(CMD_DONE), .CMD_FAIL(CMD_FAIL),
   .READ_FREQ(READ_FREQ), .TXD(TXD));

//--- verif/ucmd_dev.sv
module ucmd_dev #(
   parameter int BC = 16,
   parameter logic [19:0] FAC = 20'h20000
) (
   input wire logic clk,
   input wire logic line_in,
   input wire logic mute,
   output logic line_out,
   output logic [19:0] freq_o,
   output logic [19:0] store_o,
   output logic amp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] b0, b1, b2, b3;
   // ==========================================
   // byte level, no session timeout modelled
   task automatic rx(output logic [7:0] b);
      @(negedge line_in);
      repeat (BC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BC) @(posedge clk);
         b[i] = line_in;
      end
      repeat (BC) @(posedge clk);
   endtask
   task automatic tx(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         line_out = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
         repeat (BC) @(negedge clk);
      end
   endtask
   initial begin
      line_out = 1'b1;
      freq_o = FAC;
      store_o = FAC;
      amp_o = 1'b1;
      forever begin
         rx(b0);
         if (b0 == 8'h99) begin
            rx(b0);
            if (b0 == 8'hAA && !mute) begin
               tx(8'hBB);
               rx(b0);
               rx(b1);
               tx(8'hCC);
               rx(b2);
               rx(b3);
               // state moves before the ack so it is seen at done
               case (b3[3:0])
                  4'h1: begin
                     freq_o = {b2, b1, b0[3:0]};
                     store_o = {b2, b1, b0[3:0]};
                  end
                  4'h5: freq_o = {b2, b1, b0[3:0]};
                  4'h2: amp_o = 1'b0;
                  4'h3: amp_o = 1'b1;
                  4'h6: freq_o = FAC;
                  default: ;
               endcase
               tx(8'hCC);
               if (b3[3:0] == 4'h4) begin
                  tx({4'h0, freq_o[3:0]});
                  tx(freq_o[11:4]);
                  tx(freq_o[19:12]);
               end
            end
         end
      end
   end
endmodule

//--- verif/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [19:0] FAC = 20'h20000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic start = 1'b0;
   logic [3:0] code = 4'h0;
   logic [19:0] freq = 20'h00000;
   logic mute = 1'b0;
   wire busy, done, fail, txd, rxd, amp;
   wire [23:0] rdf;
   wire [19:0] dfreq, dstore;
   int error_cnt = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   ucmd_host #(.BIT_CYCLES(32'h10), .GAP_CYCLES(32'h190),
      .SLOT_CYCLES(32'h64), .RSP_TO_CYCLES(32'h7D0),
      .RETRY_CYCLES(32'h1F4)) dut_u (
      .CORE_CLK(clk), .NRST(nrst), .CMD_START(start), .CMD_CODE(code),
      .CMD_FREQ(freq), .CMD_BUSY(busy), .CMD_DONE(done),
      .CMD_FAIL(fail), .READ_FREQ(rdf), .TXD(txd), .RXD(rxd));
   // model defaults match the bit time and factory value used here
   ucmd_dev dev_u (.clk(clk), .line_in(txd),
      .mute(mute), .line_out(rxd), .freq_o(dfreq), .store_o(dstore),
      .amp_o(amp));
   // ==========================================
   // helpers
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_end(input logic xf);
      int n;
      n = 0;
      while (done !== 1'b1 && fail !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      check({22'h0, done, fail}, {22'h0, !xf, xf});
   endtask
   task automatic run(input logic [3:0] c, input logic [19:0] f,
      input logic xf);
      @(negedge clk);
      code = c;
      freq = f;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wait_end(xf);
   endtask
   // ==========================================
   // scenarios
   task automatic t_volatile();
      run(4'h5, 20'h47865, 1'b0);
      check({4'h0, dfreq}, 24'h047865);
      check({4'h0, dstore}, {4'h0, FAC});
   endtask
   task automatic t_store();
      run(4'h1, 20'h01234, 1'b0);
      check({4'h0, dstore}, 24'h001234);
   endtask
   task automatic t_read();
      run(4'h4, 20'h99999, 1'b0);
      check(rdf, 24'h012304);
      check({4'h0, dfreq}, 24'h001234);
   endtask
   task automatic t_busy();
      @(negedge clk);
      code = 4'h2;
      start = 1'b1;
      @(negedge clk);
      code = 4'h3;
      // start held while busy must not open a second session
      repeat (50) @(negedge clk);
      start = 1'b0;
      wait_end(1'b0);
      check({23'h0, amp}, 24'h0);
      repeat (300) @(negedge clk);
      check({23'h0, busy}, 24'h0);
   endtask
   task automatic t_amp_on();
      run(4'h3, 20'h00000, 1'b0);
      check({23'h0, amp}, 24'h1);
   endtask
   task automatic t_factory();
      run(4'h6, 20'h00000, 1'b0);
      check({4'h0, dfreq}, {4'h0, FAC});
   endtask
   task automatic t_fail();
      mute = 1'b1;
      run(4'h5, 20'h11111, 1'b1);
      mute = 1'b0;
      check({4'h0, dfreq}, {4'h0, FAC});
   endtask
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      t_volatile();
      t_store();
      t_read();
      t_busy();
      t_amp_on();
      t_factory();
      t_fail();
      tally_and_finish();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
